// *** rtl/ahgs_gate_sequencer.sv ***
`timescale 1ns/1ns
// Function
// - Current codes adapt only when gate control select is 10 or 11.
// - Active freewheel: PWM rise starts freewheel cross-conduction, opposite gate sunk, PWM gate off.
// - After freewheel interval, PWM gate sourced with adaptive pre-charge code for pre-charge time.
// - Then charge current; turn-on delay measured; charge ends at high threshold crossing.
// - Post-charge raises code one step per cycle to maximum until filter time ends.
// - Pre-charge code stays between lowest step and maximum drive code.
// - Enable write of one loads pre-charge code with min(initial, maximum).
// - No filter: longer delay increases, shorter delay decreases pre-charge code.
// - Adaptation step is one code when step bit is 0, two when 1.
// - Filter on: change only when last two cycles agree, else unchanged.
// - Active freewheel: PWM fall delays turn-off by freewheel interval for symmetry.
// - After symmetrization, PWM gate sunk with adaptive pre-discharge code for its duration.
// - Then discharge current; turn-off delay measured; discharge ends when active interval expires.
// - Active interval starts after symmetrization; then opposite sourced if node below low threshold.
// - Enable write loads pre-discharge code min(initial, maximum); code always clamped.
// - Pre-discharge code follows turn-off delay error with the same filter option.
// - Without active freewheel the complementary switch is never turned on.
// - Without active freewheel the freewheel interval is skipped at both PWM edges; the active interval still ends discharge.
// - Low-side mapping swaps the switch roles and the two thresholds.
// - Measured turn-on and turn-off delays are readable by software.
module ahgs_gate_sequencer
	import ahgs_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        pwm_input,
	input  wire logic        sh_above_high,
	input  wire logic        sh_below_low,
	output logic      [1:0]  hs_drive,
	output logic      [5:0]  hs_current,
	output logic      [1:0]  ls_drive,
	output logic      [5:0]  ls_current
);

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [1:0]  gc_sel_r;
	logic        filt_r;
	logic        step_r;
	logic        post_dis_r;
	logic        pwm_en_r;
	logic        afw_r;
	logic        low_side_r;
	logic [5:0]  max_r;
	logic [5:0]  pre_init_r;
	logic [5:0]  pdis_init_r;
	logic [7:0]  pre_time_r;
	logic [7:0]  pdis_time_r;
	logic [5:0]  chg_cur_r;
	logic [5:0]  dis_cur_r;
	logic [5:0]  fw_cur_r;
	logic [7:0]  fw_ccp_r;
	logic [7:0]  act_ccp_r;
	logic [7:0]  filt_time_r;
	logic [7:0]  ton_tgt_r;
	logic [7:0]  toff_tgt_r;
	logic        en_load;

	assign en_load = reg_wr && (reg_addr == ADDR_HALFBRIDGE_MODE_REG) && reg_wdata[HM_EN_BIT];

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			gc_sel_r    <= 2'h0;
			filt_r      <= 1'b0;
			step_r      <= 1'b0;
			post_dis_r  <= 1'b0;
			pwm_en_r    <= 1'b0;
			afw_r       <= 1'b0;
			low_side_r  <= 1'b0;
			max_r       <= RST_MAXCUR;
			pre_init_r  <= RST_INITCUR;
			pdis_init_r <= RST_INITCUR;
			pre_time_r  <= RST_TIME;
			pdis_time_r <= RST_TIME;
			chg_cur_r   <= RST_CHGCUR;
			dis_cur_r   <= RST_CHGCUR;
			fw_cur_r    <= RST_CHGCUR;
			fw_ccp_r    <= RST_TIME;
			act_ccp_r   <= RST_TIME;
			filt_time_r <= RST_TIME;
			ton_tgt_r   <= RST_TARGET;
			toff_tgt_r  <= RST_TARGET;
		end else if (reg_wr) begin
			unique case (reg_addr)
				ADDR_GENERAL_CONTROL_REG: begin
					gc_sel_r   <= reg_wdata[GC_SEL_LSB +: 2];
					filt_r     <= reg_wdata[GC_FILT_BIT];
					step_r     <= reg_wdata[GC_STEP_BIT];
					post_dis_r <= reg_wdata[GC_POST_BIT];
				end
				ADDR_HALFBRIDGE_MODE_REG: begin
					pwm_en_r   <= reg_wdata[HM_EN_BIT];
					afw_r      <= reg_wdata[HM_AFW_BIT];
					low_side_r <= reg_wdata[HM_LS_BIT];
				end
				ADDR_MAXCUR: max_r <= reg_wdata[CUR_LO_LSB +: 6];
				ADDR_INITCUR: begin
					pre_init_r  <= reg_wdata[CUR_LO_LSB +: 6];
					pdis_init_r <= reg_wdata[CUR_MID_LSB +: 6];
				end
				ADDR_PRETIME: begin
					pre_time_r  <= reg_wdata[CUR_LO_LSB +: 8];
					pdis_time_r <= reg_wdata[CUR_MID_LSB +: 8];
				end
				ADDR_PHASECUR: begin
					chg_cur_r <= reg_wdata[CUR_LO_LSB +: 6];
					dis_cur_r <= reg_wdata[CUR_MID_LSB +: 6];
					fw_cur_r  <= reg_wdata[CUR_HI_LSB +: 6];
				end
				ADDR_TIMING: begin
					fw_ccp_r    <= reg_wdata[CUR_LO_LSB +: 8];
					act_ccp_r   <= reg_wdata[CUR_MID_LSB +: 8];
					filt_time_r <= reg_wdata[CUR_HI_LSB +: 8];
				end
				ADDR_TARGET: begin
					ton_tgt_r  <= reg_wdata[CUR_LO_LSB +: 8];
					toff_tgt_r <= reg_wdata[CUR_MID_LSB +: 8];
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	ahgs_state_t st_r;
	ahgs_state_t st_nxt;
	logic [7:0]  tmr_r;
	logic [7:0]  tmr_nxt;
	logic [7:0]  ccp_r;
	logic [7:0]  meas_r;
	logic [7:0]  ton_eff_r;
	logic [7:0]  toff_eff_r;
	logic [5:0]  post_r;
	logic        pwm_d_r;
	logic        rise;
	logic        fall;
	logic        on_cross;
	logic        off_cross;
	logic        ton_evt;
	logic        toff_evt;
	logic        toff_seen_r;
	logic        adapt_on;

	assign rise      = pwm_input && !pwm_d_r;
	assign fall      = !pwm_input && pwm_d_r;
	assign on_cross  = low_side_r ? sh_below_low : sh_above_high;
	assign off_cross = low_side_r ? sh_above_high : sh_below_low;
	assign adapt_on  = gc_sel_r[1];
	assign ton_evt   = (st_r == ST_CHG) && on_cross;
	assign toff_evt  = (st_r == ST_PREDIS || st_r == ST_DIS) && !toff_seen_r && off_cross;

	always_comb begin
		st_nxt  = st_r;
		tmr_nxt = (tmr_r == CNT_ZERO) ? CNT_ZERO : tmr_r - 8'h01;
		if (!pwm_en_r) begin
			st_nxt = ST_IDLE;
		end else if (rise) begin
			if (afw_r) begin
				st_nxt  = ST_ON_CCP;
				tmr_nxt = fw_ccp_r;
			end else begin
				st_nxt  = (gc_sel_r == 2'h0) ? ST_CHG : ST_PRECHG;
				tmr_nxt = pre_time_r;
			end
		end else if (fall) begin
			if (afw_r) begin
				st_nxt  = ST_SYMM;
				tmr_nxt = fw_ccp_r;
			end else begin
				st_nxt  = (gc_sel_r == 2'h0) ? ST_DIS : ST_PREDIS;
				tmr_nxt = pdis_time_r;
			end
		end else begin
			unique case (st_r)
				ST_ON_CCP: if (tmr_r == CNT_ZERO) begin
					st_nxt  = (gc_sel_r == 2'h0) ? ST_CHG : ST_PRECHG;
					tmr_nxt = pre_time_r;
				end
				ST_PRECHG: if (tmr_r == CNT_ZERO) begin
					st_nxt = ST_CHG;
				end
				ST_CHG: if (on_cross) begin
					st_nxt  = post_dis_r ? ST_ON_HOLD : ST_POSTCHG;
					tmr_nxt = filt_time_r;
				end
				ST_POSTCHG: if (tmr_r == CNT_ZERO) begin
					st_nxt = ST_ON_HOLD;
				end
				ST_SYMM: if (tmr_r == CNT_ZERO) begin
					st_nxt  = (gc_sel_r == 2'h0) ? ST_DIS : ST_PREDIS;
					tmr_nxt = pdis_time_r;
				end
				ST_PREDIS: if (tmr_r == CNT_ZERO) begin
					st_nxt = ST_DIS;
				end
				ST_DIS: if (ccp_r == CNT_ZERO) begin
					st_nxt  = (afw_r && off_cross) ? ST_OFF_FW : ST_OFF_HOLD;
					tmr_nxt = filt_time_r;
				end
				ST_OFF_FW: if (tmr_r == CNT_ZERO) begin
					st_nxt = ST_OFF_HOLD;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_r    <= ST_IDLE;
			tmr_r   <= CNT_ZERO;
			pwm_d_r <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			tmr_r   <= tmr_nxt;
			pwm_d_r <= pwm_input;
		end
	end

	// Active interval runs alongside pre-discharge and discharge.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ccp_r <= CNT_ZERO;
		end else if ((st_nxt == ST_PREDIS || st_nxt == ST_DIS) && !(st_r == ST_PREDIS || st_r == ST_DIS)) begin
			ccp_r <= act_ccp_r;
		end else if (ccp_r != CNT_ZERO) begin
			ccp_r <= ccp_r - 8'h01;
		end
	end

	// Delays count from the end of the symmetric hold or freewheel interval.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meas_r      <= CNT_ZERO;
			ton_eff_r   <= CNT_ZERO;
			toff_eff_r  <= CNT_ZERO;
			toff_seen_r <= 1'b0;
		end else begin
			if ((st_nxt == ST_PRECHG || st_nxt == ST_CHG || st_nxt == ST_PREDIS || st_nxt == ST_DIS)
			    && st_nxt != st_r && !(st_r == ST_PRECHG || st_r == ST_PREDIS)) begin
				meas_r      <= CNT_ZERO;
				toff_seen_r <= 1'b0;
			end else if (meas_r != CNT_FULL) begin
				meas_r <= meas_r + 8'h01;
			end
			if (ton_evt) begin
				ton_eff_r <= meas_r;
			end
			if (toff_evt) begin
				toff_eff_r  <= meas_r;
				toff_seen_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Adaptation of pre-charge and pre-discharge codes
	// ----------------------------------------------------------------
	logic [5:0] pre_r;
	logic [5:0] pdis_r;
	logic       ton_long_r;
	logic       ton_short_r;
	logic       toff_long_r;
	logic       toff_short_r;

	function automatic logic [5:0] adapt(input logic [5:0] code, input logic lng, input logic sht,
	                                     input logic plng, input logic psht, input logic [5:0] top);
		logic [6:0] sum;
		logic [5:0] res;
		logic       up;
		logic       dn;
		up  = lng && (!filt_r || plng);
		dn  = sht && (!filt_r || psht);
		res = code;
		if (up) begin
			sum = {1'b0, code} + (step_r ? 7'h02 : 7'h01);
			res = (sum > {1'b0, top}) ? top : sum[5:0];
		end else if (dn) begin
			res = (code > (step_r ? 6'h01 : 6'h00)) ? code - (step_r ? 6'h02 : 6'h01) : CODE_LOWEST;
		end
		return (res > top) ? top : res;
	endfunction

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pre_r        <= CODE_LOWEST;
			pdis_r       <= CODE_LOWEST;
			ton_long_r   <= 1'b0;
			ton_short_r  <= 1'b0;
			toff_long_r  <= 1'b0;
			toff_short_r <= 1'b0;
		end else if (en_load) begin
			pre_r  <= (pre_init_r < max_r) ? pre_init_r : max_r;
			pdis_r <= (pdis_init_r < max_r) ? pdis_init_r : max_r;
		end else begin
			if (ton_evt && adapt_on) begin
				pre_r       <= adapt(pre_r, meas_r > ton_tgt_r, meas_r < ton_tgt_r, ton_long_r, ton_short_r, max_r);
				ton_long_r  <= meas_r > ton_tgt_r;
				ton_short_r <= meas_r < ton_tgt_r;
			end else if (pre_r > max_r) begin
				pre_r <= max_r;
			end
			if (toff_evt && adapt_on) begin
				pdis_r       <= adapt(pdis_r, meas_r > toff_tgt_r, meas_r < toff_tgt_r, toff_long_r,
				                      toff_short_r, max_r);
				toff_long_r  <= meas_r > toff_tgt_r;
				toff_short_r <= meas_r < toff_tgt_r;
			end else if (pdis_r > max_r) begin
				pdis_r <= max_r;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			post_r <= CODE_LOWEST;
		end else if (st_r != ST_POSTCHG) begin
			post_r <= chg_cur_r;
		end else if (post_r < max_r) begin
			post_r <= post_r + 6'h01;
		end
	end

	// ----------------------------------------------------------------
	// Gate outputs
	// ----------------------------------------------------------------
	logic [1:0] pwm_drv;
	logic [5:0] pwm_cur;
	logic [1:0] opp_drv;
	logic [5:0] opp_cur;

	always_comb begin
		pwm_drv = DRV_OFF;
		pwm_cur = CODE_LOWEST;
		opp_drv = DRV_OFF;
		opp_cur = CODE_LOWEST;
		unique case (st_r)
			ST_IDLE, ST_OFF_HOLD: pwm_drv = DRV_OFF;
			ST_ON_CCP: begin
				opp_drv = DRV_SINK;
				opp_cur = fw_cur_r;
			end
			ST_PRECHG: begin
				pwm_drv = DRV_SOURCE;
				pwm_cur = adapt_on ? pre_r : pre_init_r;
			end
			ST_CHG: begin
				pwm_drv = DRV_SOURCE;
				pwm_cur = chg_cur_r;
			end
			ST_POSTCHG: begin
				pwm_drv = DRV_SOURCE;
				pwm_cur = post_r;
			end
			ST_ON_HOLD, ST_SYMM: begin
				pwm_drv = DRV_SOURCE;
				pwm_cur = max_r;
			end
			ST_PREDIS: begin
				pwm_drv = DRV_SINK;
				pwm_cur = adapt_on ? pdis_r : pdis_init_r;
			end
			ST_DIS: begin
				pwm_drv = DRV_SINK;
				pwm_cur = dis_cur_r;
			end
			ST_OFF_FW: begin
				opp_drv = DRV_SOURCE;
				opp_cur = fw_cur_r;
			end
			default: ;
		endcase
		if (!afw_r) begin
			opp_drv = DRV_OFF;
			opp_cur = CODE_LOWEST;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hs_drive   <= DRV_OFF;
			hs_current <= CODE_LOWEST;
			ls_drive   <= DRV_OFF;
			ls_current <= CODE_LOWEST;
		end else begin
			hs_drive   <= low_side_r ? opp_drv : pwm_drv;
			hs_current <= low_side_r ? opp_cur : pwm_cur;
			ls_drive   <= low_side_r ? pwm_drv : opp_drv;
			ls_current <= low_side_r ? pwm_cur : opp_cur;
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_GENERAL_CONTROL_REG:  reg_rdata <= {27'h0, post_dis_r, step_r, filt_r, gc_sel_r};
				ADDR_HALFBRIDGE_MODE_REG:   reg_rdata <= {29'h0, low_side_r, afw_r, pwm_en_r};
				ADDR_MAXCUR:   reg_rdata <= {26'h0, max_r};
				ADDR_INITCUR:  reg_rdata <= {18'h0, pdis_init_r, 2'h0, pre_init_r};
				ADDR_PRETIME:  reg_rdata <= {16'h0, pdis_time_r, pre_time_r};
				ADDR_PHASECUR: reg_rdata <= {10'h0, fw_cur_r, 2'h0, dis_cur_r, 2'h0, chg_cur_r};
				ADDR_TIMING:   reg_rdata <= {8'h0, filt_time_r, act_ccp_r, fw_ccp_r};
				ADDR_TARGET:   reg_rdata <= {16'h0, toff_tgt_r, ton_tgt_r};
				ADDR_EFFDLY:   reg_rdata <= {16'h0, toff_eff_r, ton_eff_r};
				ADDR_CODES:    reg_rdata <= {18'h0, pdis_r, 2'h0, pre_r};
				default:       reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_afw_off_opp: assert property (@(posedge mclk) disable iff (!rstn)
		!afw_r |=> (low_side_r ? hs_drive : ls_drive) == DRV_OFF)
		else $error("complementary gate driven without active freewheel");

	a_rise_to_ccp: assert property (@(posedge mclk) disable iff (!rstn)
		(pwm_en_r && rise && afw_r) |=> st_r == ST_ON_CCP ##1 (!afw_r || (low_side_r ? hs_drive : ls_drive) == DRV_SINK))
		else $error("rising edge did not start freewheel interval");

	a_rise_no_ccp: assert property (@(posedge mclk) disable iff (!rstn)
		(pwm_en_r && rise && !afw_r) |=> st_r != ST_ON_CCP)
		else $error("cross-conduction interval entered without active freewheel");

	a_fall_symm: assert property (@(posedge mclk) disable iff (!rstn)
		(pwm_en_r && fall && afw_r) |=> st_r == ST_SYMM ##1 (low_side_r ? ls_drive : hs_drive) == DRV_SOURCE)
		else $error("turn-off not held for symmetrization");

	a_post_step: assert property (@(posedge mclk) disable iff (!rstn)
		(st_r == ST_POSTCHG && $past(st_r) == ST_POSTCHG && $stable(max_r))
		|-> post_r == (($past(post_r) < max_r) ? $past(post_r) + 6'h01 : $past(post_r)))
		else $error("post-charge step wrong");

	a_load_init: assert property (@(posedge mclk) disable iff (!rstn)
		en_load |=> pre_r == (($past(pre_init_r) < $past(max_r)) ? $past(pre_init_r) : $past(max_r)))
		else $error("pre-charge code not loaded on enable");

	a_pre_clamp: assert property (@(posedge mclk) disable iff (!rstn)
		$stable(max_r) |-> (pre_r <= max_r && pdis_r <= max_r))
		else $error("current code above maximum");

	a_agc_freeze: assert property (@(posedge mclk) disable iff (!rstn)
		(!adapt_on && !en_load && pre_r <= max_r) |=> $stable(pre_r))
		else $error("code adapted while adaptation off");

	a_step_size: assert property (@(posedge mclk) disable iff (!rstn)
		(ton_evt && adapt_on && !en_load && !filt_r && meas_r > ton_tgt_r && step_r
		 && {1'b0, pre_r} + 7'h02 <= {1'b0, max_r})
		|=> pre_r == $past(pre_r) + 6'h02)
		else $error("two-step adaptation wrong");

	a_filt_hold: assert property (@(posedge mclk) disable iff (!rstn)
		(ton_evt && adapt_on && !en_load && filt_r && !(meas_r > ton_tgt_r && ton_long_r)
		 && !(meas_r < ton_tgt_r && ton_short_r) && pre_r <= max_r)
		|=> $stable(pre_r))
		else $error("filtered code changed without agreement");

	a_eff_read: assert property (@(posedge mclk) disable iff (!rstn)
		(reg_rd && reg_addr == ADDR_EFFDLY) |=> reg_rdata == {16'h0, $past(toff_eff_r), $past(ton_eff_r)})
		else $error("effective delay readout wrong");

endmodule

// *** rtl/ahgs_pkg.sv ***
package ahgs_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_GENERAL_CONTROL_REG  = 8'h00;
	localparam logic [7:0] ADDR_HALFBRIDGE_MODE_REG   = 8'h04;
	localparam logic [7:0] ADDR_MAXCUR   = 8'h08;
	localparam logic [7:0] ADDR_INITCUR  = 8'h0c;
	localparam logic [7:0] ADDR_PRETIME  = 8'h10;
	localparam logic [7:0] ADDR_PHASECUR = 8'h14;
	localparam logic [7:0] ADDR_TIMING   = 8'h18;
	localparam logic [7:0] ADDR_TARGET   = 8'h1c;
	localparam logic [7:0] ADDR_EFFDLY   = 8'h20;
	localparam logic [7:0] ADDR_CODES    = 8'h24;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int GC_SEL_LSB   = 0;
	localparam int GC_FILT_BIT  = 2;
	localparam int GC_STEP_BIT  = 3;
	localparam int GC_POST_BIT  = 4;
	localparam int HM_EN_BIT    = 0;
	localparam int HM_AFW_BIT   = 1;
	localparam int HM_LS_BIT    = 2;
	localparam int CUR_LO_LSB   = 0;
	localparam int CUR_MID_LSB  = 8;
	localparam int CUR_HI_LSB   = 16;

	// ----------------------------------------------------------------
	// Values after reset and current codes
	// ----------------------------------------------------------------
	localparam logic [5:0] CODE_LOWEST  = 6'h00;
	localparam logic [5:0] CODE_TOP     = 6'h3f;
	localparam logic [5:0] RST_MAXCUR   = 6'h3f;
	localparam logic [5:0] RST_INITCUR  = 6'h10;
	localparam logic [7:0] RST_TIME     = 8'h04;
	localparam logic [5:0] RST_CHGCUR   = 6'h08;
	localparam logic [7:0] RST_TARGET   = 8'h10;
	localparam logic [7:0] CNT_ZERO     = 8'h00;
	localparam logic [7:0] CNT_FULL     = 8'hff;

	// ----------------------------------------------------------------
	// Gate drive modes and sequencer states
	// ----------------------------------------------------------------
	localparam logic [1:0] DRV_OFF    = 2'h0;
	localparam logic [1:0] DRV_SOURCE = 2'h1;
	localparam logic [1:0] DRV_SINK   = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ON_CCP, ST_PRECHG, ST_CHG, ST_POSTCHG, ST_ON_HOLD,
		ST_SYMM, ST_PREDIS, ST_DIS, ST_OFF_FW, ST_OFF_HOLD
	} ahgs_state_t;

endpackage

// *** verif/adaptive_halfbridge_gate_sequencer_test.sv ***
`timescale 1ns/1ns
module adaptive_halfbridge_gate_sequencer_test;
	import ahgs_pkg::*;
	localparam logic [5:0] MX  = 6'h0c;
	localparam logic [5:0] CHG = 6'h08;
	localparam logic [5:0] DIS = 6'h07;
	localparam logic [5:0] FW  = 6'h0a;
	localparam int         FWT = 4;
	logic        mclk      = 1'b0;
	logic        rstn      = 1'b0;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic        rd_d      = 1'b0;
	logic        pwm_input = 1'b0;
	logic [7:0]  sw_dly    = 8'h10;
	logic [2:0]  hbm       = 3'h0;
	logic [5:0]  pre_e     = 6'h00;
	logic [5:0]  pd_e      = 6'h00;
	logic        prev_l    = 1'b0;
	logic [31:0] reg_rdata;
	logic        sh_above_high;
	logic        sh_below_low;
	logic [1:0]  hs_drive;
	logic [1:0]  ls_drive;
	logic [5:0]  hs_current;
	logic [5:0]  ls_current;
	logic [31:0] expq [$];
	int          mismatches = 0;
	int          num_checks = 0;
	int          seed       = 31;
	logic [31:0] rst_v [11] = '{32'h0, 32'h0, 32'h3f, 32'h1010, 32'h0404, 32'h080808, 32'h040404, 32'h1010,
		32'h0, 32'h0, 32'h0};
	logic [8:0]  cyc_t [11] = '{{5'h02, 3'h3, 1'b1}, {5'h02, 3'h3, 1'b0}, {5'h0a, 3'h3, 1'b0}, {5'h0a, 3'h3, 1'b1},
		{5'h0a, 3'h3, 1'b0}, {5'h06, 3'h3, 1'b1}, {5'h06, 3'h3, 1'b1}, {5'h02, 3'h1, 1'b1}, {5'h02, 3'h5, 1'b0},
		{5'h01, 3'h5, 1'b1}, {5'h10, 3'h5, 1'b0}};
	wire  [1:0]  p_d = hbm[HM_LS_BIT] ? ls_drive : hs_drive;
	wire  [1:0]  o_d = hbm[HM_LS_BIT] ? hs_drive : ls_drive;
	wire  [5:0]  p_c = hbm[HM_LS_BIT] ? ls_current : hs_current;
	wire  [5:0]  o_c = hbm[HM_LS_BIT] ? hs_current : ls_current;

	ahgs_gate_sequencer u_ahgs_gate_sequencer (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_input(pwm_input),
		.sh_above_high(sh_above_high), .sh_below_low(sh_below_low), .hs_drive(hs_drive),
		.hs_current(hs_current), .ls_drive(ls_drive), .ls_current(ls_current));
	ahgs_bridge_model u_ahgs_bridge_model (.mclk(mclk), .rstn(rstn), .hs_drive(hs_drive), .ls_drive(ls_drive),
		.ls_map(hbm[HM_LS_BIT]), .sw_dly(sw_dly), .sh_above_high(sh_above_high), .sh_below_low(sh_below_low));

	always #25 mclk = ~mclk;

	// --------------------------------------------------------
	// Checking
	// --------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge mclk) rd_d <= reg_rd;

	// Read data stand only in the cycle after the strobe.
	always @(negedge mclk) begin
		if (rd_d)
			check("rdata", expq.pop_front(), reg_rdata);
		if (rstn && !hbm[HM_AFW_BIT] && o_d !== DRV_OFF)
			check("opposite_off", 32'(DRV_OFF), 32'(o_d));
	end

	// --------------------------------------------------------
	// Stimulus
	// --------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		if (a == ADDR_HALFBRIDGE_MODE_REG) begin
			hbm = d[2:0];
			if (d[HM_EN_BIT]) begin
				pre_e = (6'h10 < MX) ? 6'h10 : MX;
				pd_e  = (6'h05 < MX) ? 6'h05 : MX;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		expq.push_back(e);
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask

	function automatic logic [5:0] adj(input logic [5:0] c, input logic lg, input logic st);
		int v;
		v = lg ? int'(c) + (st ? 2 : 1) : int'(c) - (st ? 2 : 1);
		if (v < 0)
			v = 0;
		if (v > int'(MX))
			v = int'(MX);
		return 6'(v);
	endfunction

	task automatic run_edge(input logic lvl, input logic [5:0] code, input logic pd);
		int   n;
		int   mid;
		int   q;
		logic sa;
		logic sb;
		n   = 0;
		mid = 0;
		q   = 0;
		sa  = 1'b0;
		sb  = 1'b0;
		@(posedge mclk);
		pwm_input <= lvl;
		while (p_d !== (lvl ? DRV_SOURCE : DRV_SINK) && n < 200) begin
			@(negedge mclk);
			n++;
			if (o_d === DRV_SINK && o_c === FW)
				sa = 1'b1;
		end
		check("edge_delay", 32'(hbm[HM_AFW_BIT]), 32'(n > FWT));
		check("first_code", 32'(code), 32'(p_c));
		if (lvl)
			check("fw_sink", 32'(hbm[HM_AFW_BIT]), 32'(sa));
		sa = 1'b0;
		n  = 0;
		while (q < 3 && n < 400) begin
			@(negedge mclk);
			n++;
			if (lvl) begin
				if (p_d === DRV_SOURCE && p_c === CHG)
					sb = 1'b1;
				if (sb && p_c > CHG && p_c < MX)
					mid++;
				q = (sb && p_c === MX) ? 3 : 0;
			end else begin
				if (p_d === DRV_SINK && p_c === DIS)
					sb = 1'b1;
				if (o_d === DRV_SOURCE && o_c === FW)
					sa = 1'b1;
				q = (p_d === DRV_OFF && o_d === DRV_OFF) ? q + 1 : 0;
			end
		end
		check("main_phase", 32'h1, 32'(sb));
		if (lvl)
			check("post_steps", pd ? 32'h0 : 32'(MX - CHG - 6'h01), 32'(mid));
		else
			check("fw_source", 32'(hbm[HM_AFW_BIT]), 32'(sa));
	endtask

	task automatic pwm_cycle(input logic [4:0] gc, input logic [2:0] hb, input logic lg);
		wr(ADDR_GENERAL_CONTROL_REG, 32'(gc));
		wr(ADDR_TARGET, lg ? 32'h0202 : 32'hc8c8);
		if (hb != hbm)
			wr(ADDR_HALFBRIDGE_MODE_REG, 32'(hb));
		@(posedge mclk);
		sw_dly <= {4'h1, 4'($random(seed))};
		run_edge(1'b1, (gc[1:0] == 2'h0) ? CHG : (gc[1:0] == 2'h1) ? 6'h10 : pre_e, gc[GC_POST_BIT]);
		run_edge(1'b0, (gc[1:0] == 2'h0) ? DIS : (gc[1:0] == 2'h1) ? 6'h05 : pd_e, 1'b0);
		if (gc[GC_SEL_LSB + 1] && (!gc[GC_FILT_BIT] || prev_l == lg)) begin
			pre_e = adj(pre_e, lg, gc[GC_STEP_BIT]);
			pd_e  = adj(pd_e, lg, gc[GC_STEP_BIT]);
		end
		prev_l = lg;
		rd(ADDR_CODES, {18'h0, pd_e, 2'h0, pre_e});
	endtask

	initial begin
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		for (int i = 0; i < 11; i++)
			rd(8'(4 * i), rst_v[i]);
		wr(ADDR_MAXCUR, 32'(MX));
		wr(ADDR_INITCUR, 32'h0510);
		wr(ADDR_PRETIME, 32'h0404);
		wr(ADDR_PHASECUR, {10'h0, FW, 2'h0, DIS, 2'h0, CHG});
		wr(ADDR_TIMING, 32'h00143c04);
		wr(ADDR_HALFBRIDGE_MODE_REG, 32'h3);
		rd(ADDR_CODES, {18'h0, pd_e, 2'h0, pre_e});
		wr(ADDR_CODES, $random(seed));
		wr(8'h28, $random(seed));
		rd(ADDR_CODES, {18'h0, pd_e, 2'h0, pre_e});
		rd(8'h28, 32'h0);
		for (int i = 0; i < 11; i++)
			pwm_cycle(cyc_t[i][8:4], cyc_t[i][3:1], cyc_t[i][0]);
		repeat (4) @(posedge mclk);
		conclude();
	end

	initial begin
		#(50 * 20000);
		mismatches++;
		conclude();
	end
endmodule

// *** verif/ahgs_bridge_model.sv ***
`timescale 1ns/1ns
module ahgs_bridge_model
	import ahgs_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic [1:0] hs_drive,
	input  wire logic [1:0] ls_drive,
	input  wire logic       ls_map,
	input  wire logic [7:0] sw_dly,
	output logic            sh_above_high,
	output logic            sh_below_low
);
	logic [1:0] hs_last_r;
	logic [1:0] ls_last_r;
	logic [7:0] hs_cnt_r;
	logic [7:0] ls_cnt_r;
	logic       hs_on_r;
	logic       ls_on_r;

	// --------------------------------------------------------
	// Gate charge
	// --------------------------------------------------------
	// A gate only flips after being driven the same way for sw_dly cycles.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hs_last_r <= DRV_OFF;
			hs_cnt_r  <= CNT_ZERO;
			hs_on_r   <= 1'b0;
		end else begin
			hs_last_r <= hs_drive;
			hs_cnt_r  <= (hs_drive != hs_last_r) ? CNT_ZERO : hs_cnt_r + {7'h0, hs_cnt_r != CNT_FULL};
			if (hs_drive != DRV_OFF && hs_drive == hs_last_r && hs_cnt_r >= sw_dly)
				hs_on_r <= (hs_drive == DRV_SOURCE);
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ls_last_r <= DRV_OFF;
			ls_cnt_r  <= CNT_ZERO;
			ls_on_r   <= 1'b0;
		end else begin
			ls_last_r <= ls_drive;
			ls_cnt_r  <= (ls_drive != ls_last_r) ? CNT_ZERO : ls_cnt_r + {7'h0, ls_cnt_r != CNT_FULL};
			if (ls_drive != DRV_OFF && ls_drive == ls_last_r && ls_cnt_r >= sw_dly)
				ls_on_r <= (ls_drive == DRV_SOURCE);
		end
	end

	// With the switch off the load current drags the node to the other rail.
	assign sh_above_high = ls_map ? !ls_on_r : hs_on_r;
	assign sh_below_low  = !sh_above_high;
endmodule
